/* File: shared/srp_pkg.sv */
// Package for the serial receive packet packer: register map, field layout, types
package srp_pkg;
    // Buffer and count widths
    localparam int CNT_W = 11;
    localparam int BUF_AW = 10;
    localparam int FIFO_DEPTH = 16;
    localparam logic [CNT_W-1:0] BUF_FULL = 11'h400;

    // Register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DELIM = 8'h04;
    localparam logic [7:0] ADR_PLEN = 8'h08;
    localparam logic [7:0] ADR_FLUSH = 8'h0C;
    localparam logic [7:0] ADR_IDLE = 8'h10;
    localparam logic [7:0] ADR_STAT = 8'h14;

    // Field positions
    localparam int CTRL_D1EN_BIT = 0;
    localparam int CTRL_D2EN_BIT = 1;
    localparam int CTRL_PROC_LSB = 2;
    localparam int DELIM_D2_LSB = 8;
    localparam int STAT_DRAIN_BIT = 16;
    localparam int STAT_CLOSED_BIT = 17;
    localparam int STAT_PART_BIT = 18;
    localparam int STAT_OPEN_BIT = 19;

    // Reset values
    localparam logic [7:0] RST_DELIM = 8'h00;
    localparam logic [CNT_W-1:0] RST_PLEN = 11'h000;
    localparam logic [15:0] RST_FLUSH = 16'h0000;
    localparam logic [15:0] RST_IDLE = 16'h0000;

    // Terminator handling options
    typedef enum logic [1:0] {
        SRP_PROC_PASS = 2'h0,
        SRP_PROC_PLUS1 = 2'h1,
        SRP_PROC_PLUS2 = 2'h2,
        SRP_PROC_STRIP = 2'h3
    } srp_proc_t;

    // Packer states
    typedef enum logic [0:0] {
        SRP_ST_ACC = 1'h0,
        SRP_ST_DRAIN = 1'h1
    } srp_state_t;

    // Software configuration
    typedef struct packed {
        logic d1_en;
        logic d2_en;
        srp_proc_t proc;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [CNT_W-1:0] pack_len;
        logic [15:0] flush_to;
        logic [15:0] idle_lim;
    } srp_cfg_t;

    // One byte of a packet on its way to the network
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } srp_word_t;
endpackage

/* File: hw/srp_fifo.sv */
// Parameterised valid/ready FIFO for packed bytes
`timescale 1ns/1ps
`default_nettype none
module srp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [CW-1:0] count, next_count;
    logic push, pop;

    // Honest flags straight from the occupancy count
    assign in_ready_o = (count != CW'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    // Pointer and count update
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1)) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1)) : rd_ptr;
        next_count = count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage needs no reset; an entry at rd_ptr is only popped after it has been written
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

/* File: hw/srp_packer.sv */
// Serial receive packet packer with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Buffer bytes until count equals the length threshold, then emit them as one packet.
// - Length threshold zero disables count packing; full buffer or other triggers still pack.
// - Two terminator characters, each with own enable (off at reset) and 8-bit value.
// - With the first terminator enabled, accumulate until the pattern arrives, then pack.
// - With both enabled, pack only when first is immediately followed by second.
// - A full buffer is packed at once regardless of other settings.
// - Handling option is ignored with no terminator enabled; resets to pass-through.
// - Pass-through packs immediately on match, keeping terminators in the packet.
// - Plus-one buffers exactly one more byte after the match, then packs.
// - Plus-two buffers exactly two more bytes after the match, then packs.
// - Strip packs on match but drops the terminator characters from the packet.
// - Idle gap since last byte reaching the flush timeout packs the buffer.
// - Flush timeout zero disables packing on idle gaps.
// - Connection closes after the idle limit without traffic; zero never closes.
module srp_packer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial receiver byte stream
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    // Millisecond tick
    input wire logic ms_tick_i,
    // Network transmit stream
    output srp_pkg::srp_word_t tx_word_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // Connection supervision
    input wire logic conn_up_i,
    input wire logic net_act_i,
    output logic conn_open_o,
    output logic conn_close_o
);
    import srp_pkg::*;

    // Port buffer
    logic [7:0] mem [2**BUF_AW];

    srp_state_t state, next_state;
    logic [CNT_W-1:0] wr_cnt, next_wr_cnt, rd_ptr, next_rd_ptr, drain_len, next_drain_len, cnt_inc;
    logic partial, next_partial;
    logic [1:0] extra, next_extra, strip_n;
    logic [15:0] idle_ms, next_idle_ms;
    logic acc, hit, trig_len, trig_full, trig_delim, trig_to;
    srp_word_t fifo_in, fifo_out;
    logic fifo_in_ready, fifo_out_valid, pop;
    logic next_rx_ready, next_tx_valid;
    srp_word_t next_tx_word;
    srp_cfg_t cfg, next_cfg;
    logic [31:0] reg_rd, merged, mask, next_dat;
    logic req, wr, next_ack;
    logic conn_closed, next_conn_closed, next_conn_open, next_close;
    logic [15:0] conn_ms, next_conn_ms;
    logic traffic;

    // Byte lane mask from the select lines
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign mask[8*i +: 8] = {8{wb_sel_i[i]}};
    end

    // Packing engine: accumulate, detect triggers, drain into the FIFO
    always_comb begin
        next_state = state;
        next_wr_cnt = wr_cnt;
        next_rd_ptr = rd_ptr;
        next_drain_len = drain_len;
        next_partial = partial;
        next_extra = extra;
        next_idle_ms = idle_ms;
        acc = rx_valid_i && rx_ready_o;
        cnt_inc = wr_cnt + CNT_W'(1);
        hit = 1'b0;
        trig_len = 1'b0;
        trig_full = 1'b0;
        trig_delim = 1'b0;
        trig_to = 1'b0;
        strip_n = 2'h0;
        fifo_in.last = (rd_ptr == drain_len - CNT_W'(1));
        fifo_in.data = mem[rd_ptr[BUF_AW-1:0]];
        case (state)
            SRP_ST_ACC: begin
                if (acc) begin
                    next_wr_cnt = cnt_inc;
                    next_idle_ms = 16'h0000;
                    trig_len = (cfg.pack_len != RST_PLEN) && (cnt_inc == cfg.pack_len);
                    trig_full = (cnt_inc == BUF_FULL);
                    if (extra != 2'h0) begin
                        // Trailing bytes after a match are not themselves scanned
                        next_extra = extra - 2'h1;
                        trig_delim = (extra == 2'h1);
                    end else if (cfg.d1_en) begin
                        if (cfg.d2_en) begin
                            hit = partial && (rx_data_i == cfg.d2);
                            next_partial = !hit && (rx_data_i == cfg.d1);
                        end else begin
                            hit = (rx_data_i == cfg.d1);
                        end
                    end
                    if (hit) begin
                        case (cfg.proc)
                            SRP_PROC_PLUS1: next_extra = 2'h1;
                            SRP_PROC_PLUS2: next_extra = 2'h2;
                            SRP_PROC_STRIP: begin
                                trig_delim = 1'b1;
                                strip_n = cfg.d2_en ? 2'h2 : 2'h1;
                            end
                            default: trig_delim = 1'b1;
                        endcase
                    end
                end else if (ms_tick_i && (wr_cnt != '0) && (cfg.flush_to != RST_FLUSH)) begin
                    if (({1'b0, idle_ms} + 17'h00001) >= {1'b0, cfg.flush_to}) begin
                        trig_to = 1'b1;
                    end else begin
                        next_idle_ms = idle_ms + 16'h0001;
                    end
                end
                if (trig_len || trig_full || trig_delim || trig_to) begin
                    // Everything buffered except stripped terminators goes out; match and timer state start over
                    next_drain_len = next_wr_cnt - CNT_W'(strip_n);
                    next_rd_ptr = '0;
                    next_partial = 1'b0;
                    next_extra = 2'h0;
                    next_idle_ms = 16'h0000;
                    if (next_drain_len == '0) begin
                        next_wr_cnt = '0;
                    end else begin
                        next_state = SRP_ST_DRAIN;
                    end
                end
            end
            default: begin
                if (fifo_in_ready) begin
                    next_rd_ptr = rd_ptr + CNT_W'(1);
                    if (fifo_in.last) begin
                        next_state = SRP_ST_ACC;
                        next_wr_cnt = '0;
                    end
                end
            end
        endcase
        // The serial side stalls while a packet drains, so no byte is lost
        next_rx_ready = (next_state == SRP_ST_ACC);
    end

    // Output register stage in front of the network side
    always_comb begin
        pop = fifo_out_valid && (!tx_valid_o || tx_ready_i);
        next_tx_word = pop ? fifo_out : tx_word_o;
        next_tx_valid = pop ? 1'b1 : (tx_ready_i ? 1'b0 : tx_valid_o);
    end

    // Connection idle supervision
    always_comb begin
        traffic = acc || (tx_valid_o && tx_ready_i) || net_act_i;
        next_conn_ms = conn_ms;
        next_conn_open = conn_open_o || conn_up_i;
        next_close = 1'b0;
        next_conn_closed = conn_closed;
        if (wr && (wb_adr_i == ADR_STAT) && wb_dat_i[STAT_CLOSED_BIT] && wb_sel_i[STAT_CLOSED_BIT / 8]) begin
            next_conn_closed = 1'b0;
        end
        if (traffic || !conn_open_o) begin
            next_conn_ms = 16'h0000;
        end else if (ms_tick_i && (cfg.idle_lim != RST_IDLE)) begin
            if (({1'b0, conn_ms} + 17'h00001) >= {1'b0, cfg.idle_lim}) begin
                next_close = 1'b1;
                next_conn_open = 1'b0;
                next_conn_closed = 1'b1; // Set wins over a clear in the same cycle
                next_conn_ms = 16'h0000;
            end else begin
                next_conn_ms = conn_ms + 16'h0001;
            end
        end
    end

    // Register read mux
    always_comb begin
        if (wb_adr_i == ADR_CTRL) begin
            reg_rd = 32'({cfg.proc, cfg.d2_en, cfg.d1_en});
        end else if (wb_adr_i == ADR_DELIM) begin
            reg_rd = 32'({cfg.d2, cfg.d1});
        end else if (wb_adr_i == ADR_PLEN) begin
            reg_rd = 32'(cfg.pack_len);
        end else if (wb_adr_i == ADR_FLUSH) begin
            reg_rd = 32'(cfg.flush_to);
        end else if (wb_adr_i == ADR_IDLE) begin
            reg_rd = 32'(cfg.idle_lim);
        end else if (wb_adr_i == ADR_STAT) begin
            reg_rd = {12'h000, conn_open_o, partial, conn_closed, state == SRP_ST_DRAIN, 5'h00, wr_cnt};
        end else begin
            reg_rd = 32'h00000000;
        end
    end

    // Wishbone slave: one-cycle ack; a write lands at the edge where the master sees ack
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
        next_ack = req;
        next_dat = req ? reg_rd : wb_dat_o;
        merged = (reg_rd & ~mask) | (wb_dat_i & mask);
        next_cfg = cfg;
        if (wr) begin
            if (wb_adr_i == ADR_CTRL) begin
                next_cfg.d1_en = merged[CTRL_D1EN_BIT];
                next_cfg.d2_en = merged[CTRL_D2EN_BIT];
                next_cfg.proc = srp_proc_t'(merged[CTRL_PROC_LSB +: 2]);
            end else if (wb_adr_i == ADR_DELIM) begin
                next_cfg.d1 = merged[7:0];
                next_cfg.d2 = merged[DELIM_D2_LSB +: 8];
            end else if (wb_adr_i == ADR_PLEN) begin
                next_cfg.pack_len = merged[CNT_W-1:0];
            end else if (wb_adr_i == ADR_FLUSH) begin
                next_cfg.flush_to = merged[15:0];
            end else if (wb_adr_i == ADR_IDLE) begin
                next_cfg.idle_lim = merged[15:0];
            end
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SRP_ST_ACC;
            wr_cnt <= '0;
            rd_ptr <= '0;
            drain_len <= '0;
            partial <= 1'b0;
            extra <= 2'h0;
            idle_ms <= 16'h0000;
            rx_ready_o <= 1'b0;
            tx_word_o <= '0;
            tx_valid_o <= 1'b0;
            conn_ms <= 16'h0000;
            conn_open_o <= 1'b0;
            conn_close_o <= 1'b0;
            conn_closed <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            cfg <= '{d1_en: 1'b0, d2_en: 1'b0, proc: SRP_PROC_PASS, d1: RST_DELIM, d2: RST_DELIM,
                     pack_len: RST_PLEN, flush_to: RST_FLUSH, idle_lim: RST_IDLE};
        end else begin
            state <= next_state;
            wr_cnt <= next_wr_cnt;
            rd_ptr <= next_rd_ptr;
            drain_len <= next_drain_len;
            partial <= next_partial;
            extra <= next_extra;
            idle_ms <= next_idle_ms;
            rx_ready_o <= next_rx_ready;
            tx_word_o <= next_tx_word;
            tx_valid_o <= next_tx_valid;
            conn_ms <= next_conn_ms;
            conn_open_o <= next_conn_open;
            conn_close_o <= next_close;
            conn_closed <= next_conn_closed;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            cfg <= next_cfg;
        end
    end

    // Buffer write; slot index is the byte count before this byte
    always_ff @(posedge clk_i) begin
        if (acc) begin
            mem[wr_cnt[BUF_AW-1:0]] <= rx_data_i;
        end
    end

    // Packet FIFO toward the network
    srp_fifo #(
        .WIDTH($bits(srp_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(fifo_in),
        .in_valid_i(state == SRP_ST_DRAIN),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop)
    );

    // Checks on the packing decisions and the connection close
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_len_pack;
        (state == SRP_ST_ACC) && acc && (cfg.pack_len != 11'h000) && (cnt_inc == cfg.pack_len)
            |=> (state == SRP_ST_DRAIN) && (drain_len == $past(cnt_inc));
    endproperty
    a_len_pack: assert property (p_len_pack) else $error("length threshold did not pack");

    property p_len_zero;
        (cfg.pack_len == 11'h000) && (state == SRP_ST_ACC) && acc && !hit && (extra == 2'h0)
            && (cnt_inc != BUF_FULL) |=> (state == SRP_ST_ACC);
    endproperty
    a_len_zero: assert property (p_len_zero) else $error("zero threshold packed on count");

    property p_full;
        (state == SRP_ST_ACC) && acc && (wr_cnt == 11'h3FF) |=> (state == SRP_ST_DRAIN) && (drain_len == 11'h400);
    endproperty
    a_full: assert property (p_full) else $error("full buffer not packed");

    property p_pair;
        hit && cfg.d2_en |-> partial && (rx_data_i == cfg.d2) && (mem[wr_cnt[BUF_AW-1:0] - BUF_AW'(1)] == cfg.d1);
    endproperty
    a_pair: assert property (p_pair) else $error("two-character match out of sequence");

    property p_no_delim;
        !cfg.d1_en && (extra == 2'h0) |-> !trig_delim;
    endproperty
    a_no_delim: assert property (p_no_delim) else $error("terminator packed while disabled");

    property p_plus2;
        hit && (cfg.proc == SRP_PROC_PLUS2) && !trig_len && !trig_full
            |=> (state == SRP_ST_ACC) && (extra == 2'h2);
    endproperty
    a_plus2: assert property (p_plus2) else $error("plus-two did not wait");

    property p_strip;
        hit && (cfg.proc == SRP_PROC_STRIP) && (cnt_inc > 11'h002)
            |=> (drain_len == $past(cnt_inc) - (cfg.d2_en ? 11'h002 : 11'h001));
    endproperty
    a_strip: assert property (p_strip) else $error("strip length wrong");

    property p_to_zero;
        (cfg.flush_to == 16'h0000) && (state == SRP_ST_ACC) && !acc
            |=> (state == SRP_ST_ACC) && (wr_cnt == $past(wr_cnt));
    endproperty
    a_to_zero: assert property (p_to_zero) else $error("idle flush fired while disabled");

    property p_restart;
        (state == SRP_ST_DRAIN) && fifo_in_ready && fifo_in.last
            |=> (state == SRP_ST_ACC) && (wr_cnt == 11'h000) && !partial && (extra == 2'h0) && rx_ready_o;
    endproperty
    a_restart: assert property (p_restart) else $error("buffer not restarted after packet");

    property p_conn;
        conn_close_o |-> !conn_open_o && conn_closed && (cfg.idle_lim != 16'h0000);
    endproperty
    a_conn: assert property (p_conn) else $error("connection close inconsistent");

    c_len: cover property (trig_len);
    c_strip: cover property (hit && (cfg.proc == SRP_PROC_STRIP) && cfg.d2_en);
    c_timeout: cover property (trig_to);
    c_plus1: cover property (hit && (cfg.proc == SRP_PROC_PLUS1) ##[1:20] trig_delim);
endmodule
`default_nettype wire

/* File: tb/srp_partner.sv */
// Serial byte source and network sink facing the packer
`timescale 1ns/1ps
`default_nettype none
module srp_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial byte source
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    // Network sink
    input wire srp_pkg::srp_word_t tx_word_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic slow_i
);
    import srp_pkg::*;
    logic [7:0] src_q[$];
    srp_word_t got[$];
    int pkts = 0;
    logic [7:0] last_b = 8'h00;

    // Source holds each byte until taken; an idle data line shows the inverse of the last byte
    // so a stale value is never mistaken for a fresh one. The sink stalls every other cycle when slow.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
            tx_ready_o <= 1'b0;
        end else begin
            if (rx_valid_o && rx_ready_i) begin
                last_b = src_q.pop_front();
            end
            rx_valid_o <= src_q.size() != 0;
            rx_data_o <= (src_q.size() != 0) ? src_q[0] : ~last_b;
            if (tx_valid_i && tx_ready_o) begin
                got.push_back(tx_word_i);
                if (tx_word_i.last) begin
                    pkts++;
                end
            end
            tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/srp_packer_bench.sv */
// Self-checking bench for the serial receive packet packer
`timescale 1ns/1ps
`default_nettype none
module srp_packer_bench;
    import srp_pkg::*;
    typedef struct {
        logic [3:0] ctrl;
        logic [15:0] delim;
        logic [10:0] plen;
        int n_in;
        logic [39:0] din;
        int n_out;
        logic [39:0] dout;
    } srp_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, up = 1'b0, act = 1'b0, slow = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [31:0] dat_o;
    logic ack, rx_valid, rx_ready, tx_valid, tx_ready, open_o, close;
    logic [7:0] rx_data;
    srp_word_t tx_word;
    int mismatches = 0;
    int check_count = 0;
    int closes = 0;
    int base;
    srp_row_t rows[8];

    // Free-running core clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    // Count one-cycle close pulses from the connection supervisor
    always @(posedge clk_i) begin
        if (close === 1'b1) begin
            closes++;
        end
    end

    srp_packer i_srp_packer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .ms_tick_i(tick),
        .tx_word_o(tx_word), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .conn_up_i(up),
        .net_act_i(act), .conn_open_o(open_o), .conn_close_o(close));
    srp_partner i_srp_partner (.clk_i(clk_i), .rst_i(rst_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .tx_word_i(tx_word), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .slow_i(slow));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    // Classic single cycle; entered just after a rising edge, released only after ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        if (n >= 50) begin
            mismatches++;
            stop_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_pkts(input int n);
        int k;
        for (k = 0; k < 6000 && i_srp_partner.pkts < n; k++) begin
            @(posedge clk_i);
        end
        if (i_srp_partner.pkts < n) begin
            mismatches++;
            stop_test();
        end
        repeat (10) @(posedge clk_i);
    endtask

    // One-cycle millisecond ticks, spaced apart
    task automatic ms(input int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    task automatic push(input int n, input logic [39:0] d);
        for (int i = 0; i < n; i++) begin
            i_srp_partner.src_q.push_back(d[8*i +: 8]);
        end
    endtask

    initial begin
        rows[0] = '{4'h0, 16'h0000, 11'h004, 4, 40'h0044332211, 4, 40'h0044332211};
        rows[1] = '{4'h1, 16'h000D, 11'h000, 2, 40'h0D41, 2, 40'h0D41};
        rows[2] = '{4'h5, 16'h000D, 11'h000, 3, 40'h420D41, 3, 40'h420D41};
        rows[3] = '{4'h9, 16'h000D, 11'h000, 4, 40'h43420D41, 4, 40'h43420D41};
        rows[4] = '{4'hD, 16'h000D, 11'h000, 2, 40'h0D41, 1, 40'h41};
        rows[5] = '{4'h3, 16'h0A0D, 11'h000, 5, 40'h0A0D0D410D, 5, 40'h0A0D0D410D};
        rows[6] = '{4'hF, 16'h0A0D, 11'h000, 3, 40'h0A0D41, 1, 40'h41};
        rows[7] = '{4'hC, 16'h000D, 11'h002, 2, 40'h0D0D, 2, 40'h0D0D};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Configuration reset values, then an unmapped address
        foreach (rows[i]) begin
            if (i < 6) begin
                wb(1'b0, (i == 5) ? 8'h20 : 8'(4 * i), 32'h0);
                chk(rdat, 32'h0);
            end
        end
        $display("test reset done");
        // Table of packing cases, odd rows with a stalling sink
        foreach (rows[r]) begin
            slow <= r[0];
            wb(1'b1, ADR_CTRL, {28'h0, rows[r].ctrl});
            wb(1'b1, ADR_DELIM, {16'h0, rows[r].delim});
            wb(1'b1, ADR_PLEN, {21'h0, rows[r].plen});
            base = i_srp_partner.pkts;
            i_srp_partner.got.delete();
            push(rows[r].n_in, rows[r].din);
            wait_pkts(base + 1);
            chk(32'(i_srp_partner.pkts), 32'(base + 1));
            chk(32'(i_srp_partner.got.size()), 32'(rows[r].n_out));
            for (int i = 0; i < rows[r].n_out; i++) begin
                chk({23'h0, i_srp_partner.got[i]}, {23'h0, i == rows[r].n_out - 1, rows[r].dout[8*i +: 8]});
            end
            $display("test row %0d done", r);
        end
        // Idle flush: off at zero, then packs on the third tick
        wb(1'b1, ADR_CTRL, 32'h0);
        wb(1'b1, ADR_PLEN, 32'h0);
        i_srp_partner.got.delete();
        base = i_srp_partner.pkts;
        push(2, 40'h5251);
        ms(5);
        chk(32'(i_srp_partner.pkts), 32'(base));
        wb(1'b1, ADR_FLUSH, 32'h3);
        push(1, 40'h53);
        repeat (5) @(posedge clk_i);
        ms(2);
        chk(32'(i_srp_partner.pkts), 32'(base));
        ms(1);
        wait_pkts(base + 1);
        chk(32'(i_srp_partner.got.size()), 32'h3);
        $display("test idle flush done");
        // Full buffer with no other trigger, sink stalling
        wb(1'b1, ADR_FLUSH, 32'h0);
        slow <= 1'b1;
        i_srp_partner.got.delete();
        for (int i = 0; i < 1024; i++) begin
            i_srp_partner.src_q.push_back(8'(i));
        end
        wait_pkts(base + 2);
        chk(32'(i_srp_partner.got.size()), 32'h400);
        chk({23'h0, i_srp_partner.got[1023]}, 32'h1FF);
        $display("test full buffer done");
        // Connection idle limit: zero keeps it open, two ticks close it
        up <= 1'b1;
        @(posedge clk_i);
        up <= 1'b0;
        ms(3);
        chk({31'h0, open_o}, 32'h1);
        wb(1'b1, ADR_IDLE, 32'h2);
        act <= 1'b1;
        @(posedge clk_i);
        act <= 1'b0;
        ms(1);
        chk({31'h0, open_o}, 32'h1);
        chk(32'(closes), 32'h0);
        ms(1);
        chk({31'h0, open_o}, 32'h0);
        chk(32'(closes), 32'h1);
        wb(1'b0, ADR_STAT, 32'h0);
        chk({31'h0, rdat[STAT_CLOSED_BIT]}, 32'h1);
        // Writing one to the sticky closed flag must clear it
        wb(1'b1, ADR_STAT, 32'h1 << STAT_CLOSED_BIT);
        wb(1'b0, ADR_STAT, 32'h0);
        chk({31'h0, rdat[STAT_CLOSED_BIT]}, 32'h0);
        $display("test connection done");
        stop_test();
    end
endmodule
`default_nettype wire
